// File: src/smwc_top.sv
`timescale 1ns/100ps
`default_nettype none
module smwc_top
    import smwc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Analog detectors and clock sources
    input  wire logic        por_detect_in,
    input  wire logic        supply_low_in,
    input  wire logic        supply_warn_in,
    input  wire logic        lko_clk_in,
    input  wire logic        ext_clk_in,
    // Mode control
    input  wire logic [1:0]  stop_mode_in,
    input  wire logic        osc_stop_enable_in,
    input  wire logic        osc_range_in,
    output logic             stop2_allow_out,
    output logic             supply_mon_active_out,
    output logic             supply_mon_level_sel_out,
    output logic             warning_level_sel_out,
    output logic             chip_reset_out,
    // Interrupt requests
    output logic             supply_mon_irq_out,
    output logic             wakeup_irq_out,
    output logic             irq_req_out,
    output logic      [4:0]  irq_vector_out,
    // Shared port pin
    input  wire logic        port_dir_in,
    input  wire logic        port_data_in,
    output logic             shared_port_pin_out,
    output logic             shared_port_pin_oe_n_out,
    output logic             pin_slew_ctrl_out,
    output logic             pin_drive_ctrl_out
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [4:0]  s1;
        logic [4:0]  s2;
        logic [4:0]  s3;
        logic [4:0]  st;
        logic [4:0]  st_p;
        smwc_rst_t   rst;
        logic        mon_en;
        logic        mon_se;
        logic        mon_re;
        logic        mon_ie;
        logic        mon_flag;
        logic        lvl_sel;
        logic        warn_sel;
        logic        por_cause;
        logic        mon_cause;
        logic [2:0]  wk_per;
        logic        wk_ie;
        logic        wk_src;
        logic        wk_flag;
        logic [15:0] wk_cnt;
        logic        co_en;
        logic [2:0]  co_sel;
        logic        slew;
        logic        drive;
        logic [7:0]  co_cnt;
        logic        co_pin;
        logic        pin;
        logic        pin_oe_n;
        logic        ph_wr;
        logic [7:0]  ph_addr;
        logic [31:0] rdata;
    } smwc_state_t;

    smwc_state_t q;
    smwc_state_t d;

    function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
        return wr && (a == off);
    endfunction

    // ==========================================================
    // Derived conditions
    logic       in_stop;
    logic       mon_active;
    logic       lv_detect;
    logic       lv_reset;
    logic [4:0] rise;
    logic       ext_ok;
    logic       wk_tick;
    logic       wk_wrap;
    logic       addr_ok;

    assign in_stop    = stop_mode_in != MODE_RUN;
    assign mon_active = q.mon_en && (!in_stop || q.mon_se);
    assign lv_detect  = mon_active && q.st[SY_LOW];
    assign lv_reset   = lv_detect && q.mon_re;
    assign rise       = q.st & ~q.st_p;
    // External source only in run or a properly configured stop3
    assign ext_ok     = (stop_mode_in == MODE_RUN) ||
                        ((stop_mode_in == MODE_STOP3) && osc_stop_enable_in
                         && !osc_range_in);
    assign wk_tick    = (q.wk_per != 3'h0) &&
                        (q.wk_src ? (rise[SY_EXT] && ext_ok) : rise[SY_LKO]);
    assign wk_wrap    = wk_tick && (q.wk_cnt >= WK_TICKS[q.wk_per] - 16'h0001);
    assign addr_ok    = hsel_in && htrans_in[1] && hready_in;

    // ==========================================================
    // Next state
    always_comb begin
        logic [31:0] rd;
        logic        mon_clr;
        logic        wk_clr;
        rd      = 32'h0000_0000;
        mon_clr = 1'b0;
        wk_clr  = 1'b0;
        d  = q;

        // Three-stage sync; a change counts once stages two and three agree
        d.s1   = {ext_clk_in, lko_clk_in, supply_warn_in, supply_low_in, por_detect_in};
        d.s2   = q.s1;
        d.s3   = q.s2;
        d.st   = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.st);
        d.st_p = q.st;

        // Bus address phase; data phase is the next cycle
        d.ph_wr   = addr_ok && hwrite_in;
        d.ph_addr = haddr_in[7:0];

        // Register writes
        if (hit(q.ph_wr, q.ph_addr, OFF_PWR1)) begin
            d.mon_en = hwdata_in[P1_EN];
            d.mon_se = hwdata_in[P1_SE];
            d.mon_re = hwdata_in[P1_RE];
            d.mon_ie = hwdata_in[P1_IE];
        end
        if (hit(q.ph_wr, q.ph_addr, OFF_PWR2)) begin
            d.lvl_sel  = hwdata_in[P2_LVL];
            d.warn_sel = hwdata_in[P2_WSEL];
        end
        if (hit(q.ph_wr, q.ph_addr, OFF_WAKE)) begin
            d.wk_per = hwdata_in[WK_PER +: 3];
            d.wk_ie  = hwdata_in[WK_IE];
            d.wk_src = hwdata_in[WK_SRC];
        end
        if (hit(q.ph_wr, q.ph_addr, OFF_CLKO)) begin
            d.co_en  = hwdata_in[CO_EN];
            d.co_sel = hwdata_in[CO_SEL +: 3];
            d.slew   = hwdata_in[CO_SLEW];
            d.drive  = hwdata_in[CO_DRV];
        end

        // Monitor flag, set beats acknowledge
        mon_clr    = hit(q.ph_wr, q.ph_addr, OFF_PWR1) && hwdata_in[P1_ACK];
        d.mon_flag = (lv_detect && !q.mon_re) || (q.mon_flag && !mon_clr);

        // Wakeup timer; period zero holds the count cleared
        if (q.wk_per == 3'h0) begin
            d.wk_cnt = 16'h0000;
        end else if (wk_wrap) begin
            d.wk_cnt = 16'h0000;
        end else if (wk_tick) begin
            d.wk_cnt = q.wk_cnt + 16'h0001;
        end
        wk_clr    = hit(q.ph_wr, q.ph_addr, OFF_WAKE) && hwdata_in[WK_ACK];
        d.wk_flag = wk_wrap || (q.wk_flag && !wk_clr);

        // Clock-out divider
        if (!q.co_en || (q.co_sel == 3'h0)) begin
            d.co_cnt = 8'h00;
            d.co_pin = 1'b0;
        end else if (q.co_cnt >= CO_HALF[q.co_sel] - 8'h01) begin
            d.co_cnt = 8'h00;
            d.co_pin = ~q.co_pin;
        end else begin
            d.co_cnt = q.co_cnt + 8'h01;
        end
        d.pin      = q.co_en ? d.co_pin : port_data_in;
        d.pin_oe_n = q.co_en ? 1'b0 : ~port_dir_in;

        // Reset sequencer
        unique case (q.rst)
            RS_RUN: begin
                if (q.st[SY_POR]) begin
                    d.rst       = RS_POR;
                    d.por_cause = 1'b1;
                    d.mon_cause = 1'b1;
                end else if (lv_reset) begin
                    d.rst       = RS_LV;
                    d.por_cause = 1'b0;
                    d.mon_cause = 1'b1;
                end
            end
            RS_POR: begin
                // Level select is forced low here, so the hold ends at the low trip
                if (!q.st[SY_POR]) begin
                    d.rst = RS_LV;
                end
            end
            RS_LV: begin
                if (q.st[SY_POR]) begin
                    d.rst       = RS_POR;
                    d.por_cause = 1'b1;
                    d.mon_cause = 1'b1;
                end else if (!q.st[SY_LOW]) begin
                    d.rst = RS_RUN;
                end
            end
            default: begin
                d.rst = RS_POR;
            end
        endcase

        // Chip reset returns controls to defaults; cause bits survive
        if (q.rst != RS_RUN) begin
            d.mon_en   = RST_MON_EN;
            d.mon_se   = 1'b0;
            d.mon_re   = RST_MON_RE;
            d.mon_ie   = 1'b0;
            d.mon_flag = 1'b0;
            // A low-voltage hold keeps the chosen trip, so release waits for it
            d.lvl_sel  = (q.rst == RS_LV) ? q.lvl_sel : 1'b0;
            d.warn_sel = 1'b0;
            d.wk_per   = 3'h0;
            d.wk_ie    = 1'b0;
            d.wk_src   = 1'b0;
            d.wk_flag  = 1'b0;
            d.co_en    = 1'b0;
            d.co_sel   = 3'h0;
            d.slew     = 1'b0;
            d.drive    = 1'b0;
        end

        // Read data from the updated copy, so a write just before is seen
        unique case (haddr_in[7:0])
            OFF_PWR1: begin
                rd[P1_EN]   = d.mon_en;
                rd[P1_SE]   = d.mon_se;
                rd[P1_RE]   = d.mon_re;
                rd[P1_IE]   = d.mon_ie;
                rd[P1_FLAG] = d.mon_flag;
            end
            OFF_PWR2: begin
                rd[P2_LVL]  = d.lvl_sel;
                rd[P2_WSEL] = d.warn_sel;
                rd[P2_WARN] = q.st[SY_WARN];
            end
            OFF_WAKE: begin
                rd[WK_PER +: 3] = d.wk_per;
                rd[WK_IE]       = d.wk_ie;
                rd[WK_SRC]      = d.wk_src;
                rd[WK_FLAG]     = d.wk_flag;
            end
            OFF_CAUSE: begin
                rd[RC_POR] = d.por_cause;
                rd[RC_MON] = d.mon_cause;
            end
            OFF_CLKO: begin
                rd[CO_EN]       = d.co_en;
                rd[CO_SEL +: 3] = d.co_sel;
                rd[CO_SLEW]     = d.slew;
                rd[CO_DRV]      = d.drive;
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase
        if (addr_ok && !hwrite_in) begin
            d.rdata = rd;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            q        <= '0;
            q.mon_en <= RST_MON_EN;
            q.mon_re <= RST_MON_RE;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign hrdata_out               = q.rdata;
    assign hreadyout_out            = 1'b1;
    assign hresp_out                = 1'b0;
    assign stop2_allow_out          = !(q.mon_se && q.mon_en);
    assign supply_mon_active_out    = mon_active;
    assign supply_mon_level_sel_out = q.lvl_sel;
    assign warning_level_sel_out    = q.warn_sel;
    assign chip_reset_out           = q.rst != RS_RUN;
    assign supply_mon_irq_out       = q.mon_flag && q.mon_ie;
    assign wakeup_irq_out           = q.wk_flag && q.wk_ie;
    assign irq_req_out              = supply_mon_irq_out || wakeup_irq_out;
    // Monitor vector number is lower, so it wins
    assign irq_vector_out           = supply_mon_irq_out ? VEC_MON :
                                      (wakeup_irq_out ? VEC_WAKE : VEC_NONE);
    assign shared_port_pin_out      = q.pin;
    assign shared_port_pin_oe_n_out = q.pin_oe_n;
    assign pin_slew_ctrl_out        = q.slew;
    assign pin_drive_ctrl_out       = q.drive;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    a_stop2_refuse: assert property ((q.mon_en && q.mon_se) |-> !stop2_allow_out)
        else $error("stop2 allowed with monitor kept in stop");
    a_mon_stop_off: assert property ((in_stop && !q.mon_se) |-> !supply_mon_active_out)
        else $error("monitor active in stop");
    a_lv_reset_cause: assert property ((lv_reset && q.rst == RS_RUN && !q.st[SY_POR])
        |=> (chip_reset_out && q.mon_cause && !q.por_cause))
        else $error("low voltage reset missing");
    a_por_both_cause: assert property ((q.st[SY_POR] && q.rst == RS_RUN)
        |=> (q.rst == RS_POR && q.por_cause && q.mon_cause))
        else $error("power-on cause bits not set");
    a_lv_hold: assert property ((q.rst == RS_LV && q.st[SY_LOW]) |=> chip_reset_out)
        else $error("reset released while supply low");
    a_mon_irq_raise: assert property ((lv_detect && !q.mon_re && q.mon_ie && q.rst == RS_RUN)
        |=> supply_mon_irq_out)
        else $error("monitor interrupt not raised");
    a_wake_gated: assert property ((q.wk_per == 3'h0) |=> !$rose(q.wk_flag))
        else $error("wakeup flag with period zero");
    a_wake_stop2: assert property ((stop_mode_in == MODE_STOP2 && q.wk_src) |-> !wk_tick)
        else $error("external tick in stop2");
    a_wake_set_wins: assert property ((wk_wrap && q.rst == RS_RUN) |=> q.wk_flag)
        else $error("wakeup event lost");
    a_clko_low: assert property ((q.co_en && q.co_sel == 3'h0)
        |=> (!shared_port_pin_out && !shared_port_pin_oe_n_out))
        else $error("clock-out not held low");
    a_irq_priority: assert property ((supply_mon_irq_out && wakeup_irq_out)
        |-> irq_vector_out == VEC_MON)
        else $error("wrong vector priority");

endmodule
`default_nettype wire

// File: src/smwc_pkg.sv
package smwc_pkg;

    // ==========================================================
    // Register map, byte offsets
    localparam logic [7:0] OFF_PWR1  = 8'h00;
    localparam logic [7:0] OFF_PWR2  = 8'h04;
    localparam logic [7:0] OFF_WAKE  = 8'h08;
    localparam logic [7:0] OFF_CAUSE = 8'h0c;
    localparam logic [7:0] OFF_CLKO  = 8'h10;

    // ==========================================================
    // Field positions
    localparam int P1_EN   = 0;
    localparam int P1_SE   = 1;
    localparam int P1_RE   = 2;
    localparam int P1_IE   = 3;
    localparam int P1_FLAG = 4;
    localparam int P1_ACK  = 5;
    localparam int P2_LVL  = 0;
    localparam int P2_WSEL = 1;
    localparam int P2_WARN = 2;
    localparam int WK_PER  = 0;
    localparam int WK_IE   = 4;
    localparam int WK_SRC  = 5;
    localparam int WK_ACK  = 6;
    localparam int WK_FLAG = 7;
    localparam int RC_POR  = 0;
    localparam int RC_MON  = 1;
    localparam int CO_EN   = 0;
    localparam int CO_SEL  = 1;
    localparam int CO_SLEW = 4;
    localparam int CO_DRV  = 5;

    // ==========================================================
    // Reset values
    localparam logic RST_MON_EN = 1'b1;
    localparam logic RST_MON_RE = 1'b1;

    // ==========================================================
    // Synchroniser lanes
    localparam int SY_POR  = 0;
    localparam int SY_LOW  = 1;
    localparam int SY_WARN = 2;
    localparam int SY_LKO  = 3;
    localparam int SY_EXT  = 4;

    // ==========================================================
    // Modes, vectors and tables
    localparam logic [1:0] MODE_RUN   = 2'h0;
    localparam logic [1:0] MODE_STOP3 = 2'h1;
    localparam logic [1:0] MODE_STOP2 = 2'h2;
    localparam logic [4:0] VEC_MON    = 5'h03;
    localparam logic [4:0] VEC_WAKE   = 5'h19;
    localparam logic [4:0] VEC_NONE   = 5'h00;

    // Wakeup period in source ticks, index 0 unused
    localparam logic [15:0] WK_TICKS [8] = '{16'h0000, 16'h0008, 16'h0020, 16'h0040,
                                              16'h0080, 16'h0100, 16'h0200, 16'h0400};
    // Clock-out half period in bus clocks, index 0 unused
    localparam logic [7:0]  CO_HALF  [8] = '{8'h00, 8'h01, 8'h02, 8'h04,
                                              8'h08, 8'h10, 8'h20, 8'h40};

    typedef enum logic [1:0] {
        RS_RUN = 2'b00,
        RS_POR = 2'b01,
        RS_LV  = 2'b11
    } smwc_rst_t;

endpackage

// File: dv/smwc_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module smwc_analog_model #(
    parameter int LKO_HALF = 10,
    parameter int EXT_HALF = 7
) (
    // Requests from the bench
    input  wire logic por_req_in,
    input  wire logic low_req_in,
    input  wire logic warn_req_in,
    input  wire logic ext_run_in,
    // Detector outputs and wakeup clocks
    output logic      por_detect_out,
    output logic      supply_low_out,
    output logic      supply_warn_out,
    output var logic  lko_clk_out,
    output var logic  ext_clk_out
);
    // ==========================================================
    // Detectors
    // Comparators lag the supply and know nothing of the bus clock
    assign #13 por_detect_out  = por_req_in;
    assign #13 supply_low_out  = low_req_in;
    assign #13 supply_warn_out = warn_req_in;

    // ==========================================================
    // Clock sources
    // Slow clock runs free, scaled up so a wakeup takes hundreds of cycles, not millions
    initial lko_clk_out = 1'b0;
    always #(LKO_HALF * 50 + 3) lko_clk_out = ~lko_clk_out;

    // External oscillator stands still while it is off
    initial ext_clk_out = 1'b0;
    always begin
        #(EXT_HALF * 50 + 1);
        ext_clk_out = ext_run_in ? ~ext_clk_out : 1'b0;
    end
endmodule
`default_nettype wire

// File: dv/smwc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module smwc_top_tb
    import smwc_pkg::*;
;
    localparam int LKO_HALF = 10;
    localparam int EXT_HALF = 7;
    // Wakeup cases: {fire, range, osc stop enable, mode[1:0], source, period[2:0]}
    localparam logic [8:0] WK_CASES [9] = '{9'h101, 9'h102, 9'h109, 9'h159, 9'h0a9,
                                            9'h0d9, 9'h111, 9'h121, 9'h000};

    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, osc_se = 1'b0, osc_rng = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0, stop_mode = 2'h0;
    logic        port_dir = 1'b0, port_data = 1'b0, por_req = 1'b0, low_req = 1'b0;
    logic        warn_req = 1'b0, ext_run = 1'b0, mon_pend = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, stop2_allow, mon_active, lvl_sel, wsel, chip_rst;
    logic        mon_irq, wk_irq, irq_req, pin, oe_n, slew, drv;
    logic [4:0]  vec;
    wire         por_d, low_d, warn_d, lko, ext;
    int          n_errors = 0, tests_run = 0, cycles = 0;

    always #25 mclk_in = ~mclk_in;

    smwc_top dut (
        .mclk_in(mclk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .por_detect_in(por_d), .supply_low_in(low_d),
        .supply_warn_in(warn_d), .lko_clk_in(lko), .ext_clk_in(ext),
        .stop_mode_in(stop_mode), .osc_stop_enable_in(osc_se), .osc_range_in(osc_rng),
        .stop2_allow_out(stop2_allow), .supply_mon_active_out(mon_active),
        .supply_mon_level_sel_out(lvl_sel), .warning_level_sel_out(wsel),
        .chip_reset_out(chip_rst), .supply_mon_irq_out(mon_irq), .wakeup_irq_out(wk_irq),
        .irq_req_out(irq_req), .irq_vector_out(vec), .port_dir_in(port_dir),
        .port_data_in(port_data), .shared_port_pin_out(pin),
        .shared_port_pin_oe_n_out(oe_n), .pin_slew_ctrl_out(slew), .pin_drive_ctrl_out(drv)
    );

    smwc_analog_model #(.LKO_HALF(LKO_HALF), .EXT_HALF(EXT_HALF)) partner (
        .por_req_in(por_req), .low_req_in(low_req), .warn_req_in(warn_req),
        .ext_run_in(ext_run), .por_detect_out(por_d), .supply_low_out(low_d),
        .supply_warn_out(warn_d), .lko_clk_out(lko), .ext_clk_out(ext)
    );

    // ==========================================================
    // Checking and bus tasks
    task automatic wrap_up();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // Called just after a rising edge; returns just after the data-phase edge
    task automatic bus_req(input logic [7:0] a, input logic wr, input logic [31:0] d);
        htrans <= 2'h2;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge mclk_in);
        while (hreadyout !== 1'b1) @(posedge mclk_in);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge mclk_in);
        while (hreadyout !== 1'b1) @(posedge mclk_in);
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        bus_req(a, 1'b1, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus_req(a, 1'b0, 32'h0);
        cmp_val(hrdata, e);
    endtask

    function automatic logic probe(input int k);
        case (k)
            0: return chip_rst;
            1: return wk_irq;
            default: return pin;
        endcase
    endfunction

    // Bounded wait on a settled output, then back onto a rising edge
    task automatic wait_for(input int k, input logic v, input int lim, output int n);
        n = 0;
        @(negedge mclk_in);
        while (probe(k) !== v && n < lim) begin
            @(negedge mclk_in);
            n++;
        end
        cmp_val(32'(probe(k)), 32'(v));
        @(posedge mclk_in);
    endtask

    task automatic wk_try(input logic [8:0] c);
        int n;
        int p;
        int t;
        p = c[3] ? 2 * EXT_HALF : 2 * LKO_HALF;
        t = p * int'(WK_TICKS[c[2:0]]);
        stop_mode <= c[5:4];
        osc_se <= c[6];
        osc_rng <= c[7];
        bus_wr(OFF_WAKE, {26'h0, c[3], 1'b1, 1'b0, c[2:0]});
        if (c[8]) begin
            wait_for(1, 1'b1, t + 40, n);
            cmp_val(32'(n >= t - p), 32'h1);
            @(negedge mclk_in);
            cmp_val(32'(vec), mon_pend ? 32'(VEC_MON) : 32'(VEC_WAKE));
            @(posedge mclk_in);
        end else begin
            // A refused source must stay silent over several whole periods
            n = 0;
            repeat (400) begin
                @(negedge mclk_in);
                n += int'(wk_irq !== 1'b0);
            end
            cmp_val(32'(n), 32'h0);
            @(posedge mclk_in);
        end
        stop_mode <= MODE_RUN;
        bus_wr(OFF_WAKE, 32'h50);
        @(negedge mclk_in);
        cmp_val(32'(wk_irq), 32'h0);
        @(posedge mclk_in);
    endtask

    task automatic run_len(output int k);
        logic p;
        k = 0;
        @(negedge mclk_in);
        p = pin;
        while (pin === p && k < 200) begin
            @(negedge mclk_in);
            k++;
        end
        p = pin;
        k = 0;
        while (pin === p && k < 200) begin
            @(negedge mclk_in);
            k++;
        end
        cmp_val(32'(oe_n), 32'h0);
        @(posedge mclk_in);
    endtask

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        int n;
        logic [1:0] md;
        n = $urandom(32'h529412e0);
        tick(16);
        reset_in <= 1'b0;
        tick(1);
        rd_chk(OFF_PWR1, (32'(RST_MON_EN) << P1_EN) | (32'(RST_MON_RE) << P1_RE));
        rd_chk(OFF_PWR2, 32'h0);
        rd_chk(OFF_CAUSE, 32'h0);
        rd_chk(OFF_CLKO, 32'h0);
        bus_wr(8'h14, 32'hffff_ffff);
        rd_chk(8'h14, 32'h0);
        bus_wr(OFF_WAKE, 32'h50);
        rd_chk(OFF_WAKE, 32'h10);
        for (int i = 0; i < 12; i++) begin
            md = 2'(i / 4);
            bus_wr(OFF_PWR1, {30'h0, i[1], i[0]});
            stop_mode <= md;
            @(negedge mclk_in);
            cmp_val(32'(mon_active), 32'(i[0] && (md == MODE_RUN || i[1])));
            cmp_val(32'(stop2_allow), 32'(!(i[0] && i[1])));
            @(posedge mclk_in);
        end
        stop_mode <= MODE_RUN;
        bus_wr(OFF_PWR2, 32'h2);
        warn_req <= 1'b1;
        tick(6);
        rd_chk(OFF_PWR2, 32'h6);
        cmp_val({30'h0, wsel, lvl_sel}, 32'h2);
        cmp_val(32'(irq_req), 32'h0);
        bus_wr(OFF_PWR2, 32'h1);
        warn_req <= 1'b0;
        tick(1);
        cmp_val({30'h0, wsel, lvl_sel}, 32'h1);
        bus_wr(OFF_PWR1, 32'h8);
        low_req <= 1'b1;
        tick(6);
        rd_chk(OFF_PWR1, 32'h8);
        bus_wr(OFF_PWR1, 32'h1);
        tick(2);
        rd_chk(OFF_PWR1, 32'h11);
        cmp_val(32'(mon_irq), 32'h0);
        bus_wr(OFF_PWR1, 32'h9);
        low_req <= 1'b0;
        mon_pend = 1'b1;
        tick(1);
        cmp_val(32'({mon_irq, irq_req, vec}), 32'({2'h3, VEC_MON}));
        ext_run <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            wk_try(WK_CASES[i]);
            if (i == 0) begin
                bus_wr(OFF_PWR1, 32'h29);
                mon_pend = 1'b0;
                rd_chk(OFF_PWR1, 32'h9);
            end
        end
        bus_wr(OFF_PWR1, 32'hd);
        low_req <= 1'b1;
        wait_for(0, 1'b1, 10, n);
        tick(20);
        cmp_val(32'(chip_rst), 32'h1);
        low_req <= 1'b0;
        wait_for(0, 1'b0, 10, n);
        rd_chk(OFF_CAUSE, 32'h2);
        rd_chk(OFF_PWR1, 32'h5);
        cmp_val(32'(lvl_sel), 32'h1);
        por_req <= 1'b1;
        wait_for(0, 1'b1, 10, n);
        low_req <= 1'b1;
        tick(1);
        por_req <= 1'b0;
        tick(20);
        cmp_val(32'(chip_rst), 32'h1);
        low_req <= 1'b0;
        wait_for(0, 1'b0, 12, n);
        rd_chk(OFF_CAUSE, 32'h3);
        port_data <= 1'b1;
        bus_wr(OFF_CLKO, 32'h31);
        // Pin register lags the enable by one clock
        tick(1);
        n = 0;
        repeat (20) begin
            @(negedge mclk_in);
            n += int'(pin !== 1'b0 || oe_n !== 1'b0);
        end
        cmp_val(32'(n), 32'h0);
        cmp_val({30'h0, slew, drv}, 32'h3);
        @(posedge mclk_in);
        for (int s = 1; s < 8; s++) begin
            port_dir <= 1'($urandom);
            bus_wr(OFF_CLKO, {28'h0, 3'(s), 1'b1});
            run_len(n);
            cmp_val(32'(n), 32'(CO_HALF[s]));
        end
        bus_wr(OFF_CLKO, 32'h0);
        repeat (4) begin
            port_data <= 1'($urandom);
            port_dir <= 1'($urandom);
            tick(3);
            @(negedge mclk_in);
            cmp_val({30'h0, oe_n, pin}, {30'h0, ~port_dir, port_data});
            @(posedge mclk_in);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
